// ### verilog/fib_pkg.sv
// Purpose: constants, settings layout and carriers for the FM impulse blanker
// Assumes: one 24-bit settings register, samples arrive as one strobe per sample
// Notes:   every field position, reset value and count lives here
package fib_pkg;

    // ==================================================================
    // register map
    localparam logic [11:0] SETTINGS_ADDR  = 12'hFFC;
    localparam int          SETTINGS_W     = 24;
    // nominal preset: level detector and dynamic disable both on
    localparam logic [23:0] SETTINGS_RST   = 24'hF4CAED;

    // ==================================================================
    // field positions (lsb of each field)
    localparam int THR_LSB      = 0;
    localparam int FFWD_LSB     = 3;
    localparam int SUPP_LSB     = 6;
    localparam int LEAD_LSB     = 9;
    localparam int AGC_BIT      = 11;
    localparam int TRIGMON_BIT  = 12;
    localparam int LEVTHR_LSB   = 13;
    localparam int LEVLEAD_LSB  = 17;
    localparam int LEVSTR_LSB   = 19;
    localparam int DYNTHR_LSB   = 21;
    localparam int DYNEN_BIT    = 23;

    // ==================================================================
    // sample path and detector constants
    localparam int          SAMPLE_W         = 16;
    localparam int          DELAY_MIN        = 2;
    localparam int          DELAY_DEPTH      = 5;
    localparam int          LEV_LEAD_MAX     = 3;
    localparam int          AGC_SHIFT        = 4;
    localparam int          LPF_SHIFT        = 3;
    localparam int          FFWD_SHIFT       = 5;
    localparam logic [19:0] THR_STEP         = 20'h00100;
    localparam logic [16:0] LEV_STEP         = 17'h00080;
    localparam logic [5:0]  SUPP_UNIT        = 6'h04;
    localparam logic [5:0]  STRETCH_UNIT     = 6'h04;
    localparam logic [15:0] DYN_HOLD_SAMPLES = 16'h0020;
    localparam logic [15:0] DYN_LIMIT0       = 16'h2000;
    localparam logic [15:0] DYN_LIMIT1       = 16'h2800;
    localparam logic [15:0] DYN_LIMIT2       = 16'h3000;
    localparam logic [15:0] DYN_LIMIT3       = 16'h3800;

    // ==================================================================
    // settings register laid out msb first, matching bit positions
    typedef struct packed {
        logic       dynEnable;
        logic [1:0] dynThreshold;
        logic [1:0] levelStretch;
        logic [1:0] levelLead;
        logic [3:0] levelThreshold;
        logic       triggerMonitor;
        logic       agcShift;
        logic [1:0] pulseLeadDelay;
        logic [2:0] suppression;
        logic [2:0] feedForward;
        logic [2:0] threshold;
    } fib_settings_t;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] mpx;
        logic        [SAMPLE_W-1:0] level;
    } fib_sample_t;

endpackage : fib_pkg

// ### verilog/fib_delay_line.sv
// Purpose: sample delay line with a selectable tap for the multiplex path
// Assumes: shiftEn pulses once per sample
// Notes:   tap 0..3 selects DELAY_MIN..DELAY_MIN+3 samples of delay
`timescale 1ns/1ps
`default_nettype none
module fib_delay_line
    import fib_pkg::*;
#(
    parameter int W     = fib_pkg::SAMPLE_W,
    parameter int DEPTH = fib_pkg::DELAY_DEPTH
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                shiftEn,
    input  wire logic signed [W-1:0] din,
    input  wire logic        [1:0]   tap,
    output logic signed      [W-1:0] dout
);

    // ==================================================================
    // storage
    logic signed [W-1:0] mem [DEPTH];
    logic        [2:0]   tapIdx;

    assign tapIdx = 3'(tap) + 3'(DELAY_MIN - 1);
    assign dout   = mem[tapIdx];

    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (shiftEn) begin
            mem[0] <= din;
            for (int i = 1; i < DEPTH; i++) begin
                mem[i] <= mem[i-1];
            end
        end
    end

endmodule : fib_delay_line
`default_nettype wire

// ### verilog/fm_impulse_blanker.sv
// Purpose: impulse blanker for the FM multiplex path, two detectors and a gate
// Assumes: inValid pulses once per 304 kHz sample; settings port is synchronous
// Notes:   arithmetic is kept unsigned where possible to avoid sign surprises
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - multiplex samples pass a delay line and then the gate switch
// R2 - detector: high-pass feed forward, gain loop, comparator and monostable
// R3 - while gated, output holds a low-pass level instead of delayed samples
// R4 - field-level detector can also trigger multiplex suppression
// R5 - bit 23 enables blocking all blanking during sustained high deviation
// R6 - bits 22..21 choose the deviation threshold for dynamic disable
// R7 - bits 2..0 set comparator threshold; higher means less sensitive
// R8 - bits 5..3 add modulation-proportional desensitising
// R9 - bits 8..6 set suppression time after the last trigger
// R10 - bits 10..9 set signal delay of 2 to 5 samples
// R11 - bit 11 shifts gain-loop set point, lowering sensitivity
// R12 - bits 16..13 set level threshold; zero turns level detector off
// R13 - bits 18..17 align level trigger timing with multiplex path
// R14 - bits 20..19 set suppression stretch after level drops
// R15 - bit 12 routes internal trigger to the general output pin
// R16 - reset loads nominal preset with level and dynamic functions on
// R17 - host rewrites the settings register at address 0FFC
// R18 - host may load a recommended tuner-specific settings value
// R19 - suppression requests are ORed and gated off by dynamic disable
module fm_impulse_blanker
    import fib_pkg::*;
#(
    parameter logic [15:0] DYN_HOLD = fib_pkg::DYN_HOLD_SAMPLES
) (
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic                         regWrEn,
    input  wire logic [11:0]                  regAddr,
    input  wire logic [fib_pkg::SETTINGS_W-1:0] regWrData,
    output logic      [fib_pkg::SETTINGS_W-1:0] regRdData_r,
    input  wire logic                         inValid,
    input  wire fib_pkg::fib_sample_t         inSample,
    output logic                              outValid_r,
    output logic signed [fib_pkg::SAMPLE_W-1:0] outSample_r,
    output logic                              blankActive_r,
    output logic                              dynDisable_r,
    output logic                              generalOutputPin_r
);
    import fib_pkg::*;

    localparam int W = SAMPLE_W;

    // ==================================================================
    // helpers
    function automatic logic [W:0] absDiff(input logic signed [W:0] v);
        absDiff = v[W] ? 17'(-v) : 17'(v);
    endfunction : absDiff

    function automatic logic [5:0] holdLen(input logic [2:0] code, input logic [5:0] unit);
        holdLen = 6'(({3'h0, code} + 6'h01) * unit);
    endfunction : holdLen

    function automatic logic [15:0] dynLimit(input logic [1:0] code);
        unique case (code)
            2'h0: dynLimit = DYN_LIMIT0;
            2'h1: dynLimit = DYN_LIMIT1;
            2'h2: dynLimit = DYN_LIMIT2;
            2'h3: dynLimit = DYN_LIMIT3;
        endcase
    endfunction : dynLimit

    // ==================================================================
    // settings register
    fib_settings_t cfg_r;
    logic          wrHit;

    assign wrHit = regWrEn && (regAddr == SETTINGS_ADDR);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_r       <= fib_settings_t'(SETTINGS_RST); // [R16]
            regRdData_r <= '0;
        end else begin
            if (wrHit) begin
                cfg_r <= fib_settings_t'(regWrData); // [R17]
            end
            regRdData_r <= (regAddr == SETTINGS_ADDR) ? SETTINGS_W'(cfg_r) : '0;
        end
    end

    // ==================================================================
    // delayed signal path
    logic signed [W-1:0] delayed;

    fib_delay_line #(
        .W     (W),
        .DEPTH (DELAY_DEPTH)
    ) uDelay (
        .clk     (clk),
        .nrst    (nrst),
        .shiftEn (inValid),
        .din     (inSample.mpx),
        .tap     (cfg_r.pulseLeadDelay), // [R10]
        .dout    (delayed)              // [R1]
    );

    // low-pass of the delayed signal, the level the gate holds
    logic signed [W-1:0] lpf_r;
    logic signed [W:0]   lpfErr;
    logic signed [W-1:0] lpf_nxt;
    logic        [W:0]   lpfMag;

    assign lpfErr  = 17'(delayed) - 17'(lpf_r);
    assign lpf_nxt = lpf_r + W'(lpfErr >>> LPF_SHIFT);
    assign lpfMag  = absDiff(17'(lpf_r));

    // ==================================================================
    // multiplex interference detector
    logic signed [W-1:0] prevMpx_r;
    logic        [W:0]   hfMag;
    logic        [W:0]   agcAvg_r;
    logic        [W:0]   agc_nxt;
    logic        [19:0]  agcSet;
    logic        [19:0]  thrOffset;
    logic        [19:0]  ffTerm;
    logic        [19:0]  mpxLimit;
    logic                mpxTrig;
    logic        [5:0]   mpxHold_r;

    // first difference isolates the high-frequency content
    assign hfMag     = absDiff(17'(inSample.mpx) - 17'(prevMpx_r)); // [R2]
    assign agc_nxt   = agcAvg_r + (hfMag >> AGC_SHIFT) - (agcAvg_r >> AGC_SHIFT);
    // shifted set point doubles the reference, so the blanker gets less eager
    assign agcSet    = cfg_r.agcShift ? 20'(agcAvg_r) << 2 : 20'(agcAvg_r) << 1; // [R11]
    assign thrOffset = 20'(20'(cfg_r.threshold) * THR_STEP); // [R7]
    assign ffTerm    = 20'(20'(cfg_r.feedForward) * 20'(lpfMag >> FFWD_SHIFT)); // [R8]
    assign mpxLimit  = agcSet + thrOffset + ffTerm;
    assign mpxTrig   = 20'(hfMag) > mpxLimit; // [R2]

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prevMpx_r <= '0;
            agcAvg_r  <= '0;
            mpxHold_r <= '0;
        end else if (inValid) begin
            prevMpx_r <= inSample.mpx;
            agcAvg_r  <= agc_nxt;
            // retriggerable monostable
            if (mpxTrig) begin
                mpxHold_r <= holdLen(cfg_r.suppression, SUPP_UNIT); // [R9]
            end else if (mpxHold_r != 6'h00) begin
                mpxHold_r <= mpxHold_r - 6'h01;
            end
        end
    end

    // ==================================================================
    // field-level detector
    logic [W-1:0]            prevLev_r;
    logic [W:0]              levStep;
    logic                    levOn;
    logic                    levRaw;
    logic [LEV_LEAD_MAX-1:0] levPipe_r;
    logic [1:0]              levTap;
    logic                    levTrig;
    logic [5:0]              levHold_r;

    assign levStep = absDiff(17'({1'b0, inSample.level}) - 17'({1'b0, prevLev_r}));
    assign levOn   = cfg_r.levelThreshold != 4'h0; // [R12]
    assign levRaw  = levOn && (levStep > 17'(17'(cfg_r.levelThreshold) * LEV_STEP)); // [R4]
    // more lead means less extra delay on the level trigger
    assign levTap  = 2'(LEV_LEAD_MAX - 1) - cfg_r.levelLead;
    assign levTrig = (cfg_r.levelLead == 2'(LEV_LEAD_MAX)) ? levRaw : levPipe_r[levTap]; // [R13]

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prevLev_r <= '0;
            levPipe_r <= '0;
            levHold_r <= '0;
        end else if (inValid) begin
            prevLev_r <= inSample.level;
            levPipe_r <= {levPipe_r[LEV_LEAD_MAX-2:0], levRaw};
            if (levTrig) begin
                levHold_r <= holdLen({1'b0, cfg_r.levelStretch}, STRETCH_UNIT); // [R14]
            end else if (levHold_r != 6'h00) begin
                levHold_r <= levHold_r - 6'h01;
            end
        end
    end

    // ==================================================================
    // dynamic disable on sustained deviation
    logic [15:0] dynCnt_r;
    logic        devOver;
    logic        dynActive;

    assign devOver   = lpfMag > 17'(dynLimit(cfg_r.dynThreshold)); // [R6]
    assign dynActive = cfg_r.dynEnable && (dynCnt_r >= DYN_HOLD); // [R5]

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dynCnt_r <= '0;
        end else if (inValid) begin
            if (!devOver) begin
                dynCnt_r <= '0;
            end else if (dynCnt_r != 16'hFFFF) begin
                dynCnt_r <= dynCnt_r + 16'h0001;
            end
        end
    end

    // ==================================================================
    // gate and output
    logic                mpxReq;
    logic                levReq;
    logic                blank;
    logic signed [W-1:0] holdLevel_r;
    logic signed [W-1:0] gateOut;

    assign mpxReq  = mpxTrig || (mpxHold_r != 6'h00);
    assign levReq  = levTrig || (levHold_r != 6'h00);
    assign blank   = (mpxReq || levReq) && !dynActive; // [R19]
    // the held level is frozen at gate start so the gap stays flat
    assign gateOut = !blank ? delayed : (blankActive_r ? holdLevel_r : lpf_r); // [R3]

    always_ff @(posedge clk) begin
        if (!nrst) begin
            lpf_r              <= '0;
            holdLevel_r        <= '0;
            outSample_r        <= '0;
            outValid_r         <= 1'b0;
            blankActive_r      <= 1'b0;
            dynDisable_r       <= 1'b0;
            generalOutputPin_r <= 1'b0;
        end else begin
            outValid_r <= inValid;
            if (inValid) begin
                lpf_r         <= blank ? lpf_r : lpf_nxt;
                outSample_r   <= gateOut; // [R1]
                blankActive_r <= blank;
                dynDisable_r  <= dynActive;
                if (blank && !blankActive_r) begin
                    holdLevel_r <= lpf_r;
                end
                generalOutputPin_r <= cfg_r.triggerMonitor && (mpxTrig || levTrig); // [R15]
            end
        end
    end

endmodule : fm_impulse_blanker
`default_nettype wire

// ### verif/fib_monitor.sv
// Purpose: port-level checker for the FM impulse blanker
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module fib_monitor
    import fib_pkg::*;
#(
    parameter logic [15:0] DYN_HOLD = 16'h0020
) (
    input wire logic                                clk,
    input wire logic                                nrst,
    input wire logic                                regWrEn,
    input wire logic [11:0]                         regAddr,
    input wire logic [fib_pkg::SETTINGS_W-1:0]      regWrData,
    input wire logic [fib_pkg::SETTINGS_W-1:0]      regRdData_r,
    input wire logic                                inValid,
    input wire fib_pkg::fib_sample_t                inSample,
    input wire logic                                outValid_r,
    input wire logic signed [fib_pkg::SAMPLE_W-1:0] outSample_r,
    input wire logic                                blankActive_r,
    input wire logic                                dynDisable_r,
    input wire logic                                generalOutputPin_r
);
    // ==================================================================
    // run of blanked samples; the first two of a run may differ (lpf vs frozen)
    logic        [1:0]          blankRun_r;
    logic        [1:0]          blankRun_nxt;
    logic signed [SAMPLE_W-1:0] lastOut_r;
    assign blankRun_nxt = !blankActive_r ? 2'h0 : (blankRun_r == 2'h3) ? 2'h3 : blankRun_r + 2'h1;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            blankRun_r <= 2'h0;
            lastOut_r  <= '0;
        end else if (outValid_r) begin
            blankRun_r <= blankRun_nxt;
            lastOut_r  <= outSample_r;
        end
    end

    // ==================================================================
    // assertions
    default clocking mc @(posedge clk); endclocking
    default disable iff (!nrst);
    valid_follow_a: assert property (inValid |=> outValid_r)
        else $error("no output strobe after sample");
    valid_cause_a: assert property (outValid_r |-> $past(inValid))
        else $error("output strobe without sample");
    out_steady_a: assert property (!outValid_r |-> $stable(outSample_r))
        else $error("output moved between strobes");
    blank_hold_a: assert property (outValid_r && blankActive_r && blankRun_r >= 2'h2
        |-> outSample_r == lastOut_r) else $error("blanked output not held");
    dyn_gate_a: assert property (dynDisable_r |-> !blankActive_r)
        else $error("blanking while disabled");
    blank_sync_a: assert property ($changed(blankActive_r) |-> outValid_r)
        else $error("blank flag moved off a sample");
    dyn_sync_a: assert property ($changed(dynDisable_r) |-> outValid_r)
        else $error("disable flag moved off a sample");
    pin_sync_a: assert property ($changed(generalOutputPin_r) |-> outValid_r)
        else $error("monitor pin moved off a sample");
    rd_unmapped_a: assert property ($past(regAddr) != SETTINGS_ADDR |-> regRdData_r == '0)
        else $error("unmapped read not zero");
    rd_after_wr_a: assert property ((regWrEn && regAddr == SETTINGS_ADDR)
        ##1 (regAddr == SETTINGS_ADDR && !regWrEn) |=> regRdData_r == $past(regWrData, 2))
        else $error("written settings not read back");
    cover property ($rose(blankActive_r));
    cover property ($rose(dynDisable_r));
    cover property ($rose(generalOutputPin_r));
endmodule : fib_monitor

bind fm_impulse_blanker fib_monitor #(.DYN_HOLD(DYN_HOLD)) i_fib_monitor (
    .clk(clk), .nrst(nrst), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData_r(regRdData_r), .inValid(inValid), .inSample(inSample),
    .outValid_r(outValid_r), .outSample_r(outSample_r), .blankActive_r(blankActive_r),
    .dynDisable_r(dynDisable_r), .generalOutputPin_r(generalOutputPin_r));
`default_nettype wire

// ### verif/fib_tuner_model.sv
// Purpose: tuner front end handing multiplex and level samples to the blanker
// Assumes: bench calls send once per sample
// Notes:   data lines carry inverted junk between strobes, never the old value
`timescale 1ns/1ps
`default_nettype none
module fib_tuner_model
    import fib_pkg::*;
#(
    parameter int GAP = 3
) (
    input  wire logic                 clk,
    output var  logic                 inValid,
    output var  fib_pkg::fib_sample_t inSample
);
    initial begin
        inValid  = 1'b0;
        inSample = '0;
    end
    // paced faster than 304 kHz so the run stays short
    task automatic send(input logic [15:0] m, input logic [15:0] l);
        @(posedge clk);
        #1;
        inValid  = 1'b1;
        inSample = {m, l};
        @(posedge clk);
        #1;
        inValid  = 1'b0;
        inSample = ~inSample;
        repeat (GAP) @(posedge clk);
    endtask : send
endmodule : fib_tuner_model
`default_nettype wire

// ### verif/fm_impulse_blanker_tb.sv
// Purpose: self-checking bench for the FM impulse blanker
// Assumes: samples are sent one at a time; outputs land before send returns
// Notes:   expected samples queue at send time and are matched on outValid_r
`timescale 1ns/1ps
`default_nettype none
module fm_impulse_blanker_tb;
    import fib_pkg::*;
    logic               clk = 1'b0, nrst = 1'b0, regWrEn = 1'b0;
    logic [11:0]        regAddr = 12'hFFC;
    logic [23:0]        regWrData = 24'h000000, regRdData_r;
    logic               inValid, outValid_r, blankActive_r, dynDisable_r, generalOutputPin_r;
    fib_sample_t        inSample;
    logic signed [15:0] outSample_r;
    logic [16:0]        expQ[$];
    logic [15:0]        mpxHist[$];
    int                 mismatches = 0, total_checks = 0, nBlank = 0, nPin = 0;

    always #2 clk = ~clk;
    fib_tuner_model #(.GAP(3)) i_fib_tuner_model (.clk(clk), .inValid(inValid), .inSample(inSample));
    fm_impulse_blanker #(.DYN_HOLD(16'h0004)) i_fm_impulse_blanker (
        .clk(clk), .nrst(nrst), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData_r(regRdData_r), .inValid(inValid), .inSample(inSample),
        .outValid_r(outValid_r), .outSample_r(outSample_r), .blankActive_r(blankActive_r),
        .dynDisable_r(dynDisable_r), .generalOutputPin_r(generalOutputPin_r));

    // ==================================================================
    // checking and closing
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic ok(input logic b);
        chk({23'h000000, b}, 24'h000001);
    endtask : ok
    task automatic tally_and_finish;
        if (mismatches == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish

    always @(negedge clk) begin
        if (nrst && outValid_r === 1'b1 && expQ.size() > 0) begin
            if (expQ[0][16]) chk({8'h00, outSample_r}, {8'h00, expQ[0][15:0]});
            void'(expQ.pop_front());
            nBlank += int'(blankActive_r === 1'b1);
            nPin   += int'(generalOutputPin_r === 1'b1);
        end
    end

    // ==================================================================
    // drivers
    task automatic do_reset;
        @(posedge clk);
        #1;
        nrst = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        nrst = 1'b1;
    endtask : do_reset
    task automatic wr(input logic [11:0] a, input logic [23:0] d);
        @(posedge clk);
        #1;
        regWrEn   = 1'b1;
        regAddr   = a;
        regWrData = d;
        @(posedge clk);
        #1;
        regWrEn = 1'b0;
        regAddr = 12'hFFC;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [23:0] e);
        @(posedge clk);
        #1;
        regAddr = a;
        @(posedge clk);
        #1;
        chk(regRdData_r, e);
        regAddr = 12'hFFC;
    endtask : rd
    // c marks a sample whose delayed output is predicted d samples back
    task automatic smp(input logic [15:0] m, input logic [15:0] l, input logic c, input int d);
        mpxHist.push_front(m);
        expQ.push_back({c, c ? mpxHist[d] : 16'h0000});
        i_fib_tuner_model.send(m, l);
    endtask : smp
    // quiet run with one impulse at sample 40; counts start at the impulse
    task automatic tc(input logic [23:0] w, input logic [15:0] m, input logic [15:0] l,
                      input logic [15:0] dc);
        wr(12'hFFC, w);
        for (int i = 0; i < 81; i++) begin
            if (i == 40) begin
                nBlank = 0;
                nPin   = 0;
            end
            smp(dc + (i == 40 ? m : 16'h0000), 16'h1000 + (i == 40 ? l : 16'h0000), 1'b0, 0);
        end
    endtask : tc

    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end

    initial begin
        int          nRef;
        logic [23:0] w;
        void'($urandom(86675));
        do_reset;
        rd(12'hFFC, SETTINGS_RST);
        rd(12'hFFB, 24'h000000);
        wr(12'hFF8, 24'h123456);
        rd(12'hFFC, SETTINGS_RST);
        w = 24'($urandom);
        wr(12'hFFC, w);
        rd(12'hFFC, w);
        wr(12'hFFC, 24'hF4CAED);
        rd(12'hFFC, 24'hF4CAED);
        tc(24'h001000, 16'h4000, 16'h0000, 16'h0000);
        nRef = nBlank;
        ok(nBlank > 0);
        ok(nPin > 0);
        tc(24'h000000, 16'h4000, 16'h0000, 16'h0000);
        ok(nPin == 0);
        tc(24'h0001C0, 16'h4000, 16'h0000, 16'h0000);
        ok(nBlank > nRef);
        tc(24'h000007, 16'h0400, 16'h0000, 16'h0000);
        ok(nBlank == 0);
        tc(24'h000000, 16'h0400, 16'h0000, 16'h0000);
        ok(nBlank > 0);
        tc(24'h000038, 16'h0400, 16'h0000, 16'h2000);
        ok(nBlank == 0);
        tc(24'h000000, 16'h0400, 16'h0000, 16'h2000);
        ok(nBlank > 0);
        tc(24'h002007, 16'h0000, 16'h2000, 16'h0000);
        nRef = nBlank;
        ok(nBlank > 0);
        tc(24'h182007, 16'h0000, 16'h2000, 16'h0000);
        ok(nBlank > nRef);
        tc(24'h000007, 16'h0000, 16'h2000, 16'h0000);
        ok(nBlank == 0);
        // full lead blanks on the level step itself, no lead only three samples later
        for (int k = 0; k < 2; k++) begin
            wr(12'hFFC, k == 1 ? 24'h062007 : 24'h002007);
            for (int i = 0; i < 12; i++) begin
                smp(16'h0000, i == 3 ? 16'h3000 : 16'h1000, 1'b0, 0);
                if (i == 3) ok(blankActive_r === (k == 1));
            end
        end
        // steady high-frequency content lifts the gain loop; shifted set point ignores the step
        for (int k = 0; k < 2; k++) begin
            wr(12'hFFC, k == 1 ? 24'h000800 : 24'h000000);
            for (int i = 0; i < 60; i++) smp(i % 2 == 1 ? 16'h0200 : 16'h0000, 16'h1000, 1'b0, 0);
            smp(16'h0800, 16'h1000, 1'b0, 0);
            ok(blankActive_r === (k == 0));
        end
        for (int t = 0; t < 4; t++) begin
            wr(12'hFFC, 24'h00083F | (24'(t) << 9));
            for (int i = 0; i < 12; i++) begin
                smp(16'(i * 32) + 16'($urandom % 8), 16'h1000, i >= t + 2, t + 2);
            end
        end
        for (int c = 0; c < 5; c++) begin
            wr(12'hFFC, (c < 4 ? 24'h800000 : 24'h000000) | (24'(c % 4) << 21) | 24'h00083F);
            for (int i = 0; i < 60; i++) smp(16'h3400, 16'h1000, 1'b0, 0);
            ok(dynDisable_r === (c < 3));
            if (c < 3) ok(blankActive_r === 1'b0);
            for (int i = 0; i < 40; i++) smp(16'h0000, 16'h1000, 1'b0, 0);
        end
        ok(expQ.size() == 0);
        do_reset;
        rd(12'hFFC, SETTINGS_RST);
        tally_and_finish;
    end
endmodule : fm_impulse_blanker_tb
`default_nettype wire
